// File: verilog/fan_pwm_and_tach_monitor.sv
`timescale 1ns/1ps

// Functional notes
// - Per-fan bit 7 selects the PWM frequency.
// - Bits 6..1 give duty of code/64.
// - Zero code without override keeps output low.
// - Full code is high 63 of 64 slices.
// - Bit 0 forces the output constantly high.
// - Two-bit count divisor per fan: 1,2,4,8.
// - Divisors reset to divide by two.
// - Multiplier bit doubles the chosen base clock.
// - Source-select bit picks the low-frequency pair.
// - Eight frequencies: base pair, slow pair, doubled.
// - PWM outputs are low after reset.
// - Eight-bit tach counter fed by divided reference.
// - Reference from pin when present, else internal.
// - Reload on tach rise or preload write.
// - Counter saturates at all ones, never wraps.
// - Count of 192 raises enabled wake/management events.
// - Programmable preload sets the starting count.
// - Two tach pulses per revolution, one period.

module fan_pwm_and_tach_monitor
    import fan_pkg::*;
#(
    parameter int unsigned SLICE_CYC_SLOW_A  = fan_pkg::SLICE_CYC_C,   // 40 Hz slice.
    parameter int unsigned SLICE_CYC_SLOW_B  = fan_pkg::SLICE_CYC_D,   // 60 Hz slice.
    parameter int unsigned SLICE_CYC_SLOW_A2 = fan_pkg::SLICE_CYC_C2,  // 80 Hz slice.
    parameter int unsigned SLICE_CYC_SLOW_B2 = fan_pkg::SLICE_CYC_D2,  // 120 Hz slice.
    parameter int unsigned SLOW_TICK_CYCLES  = fan_pkg::SLOW_TICK_CYC  // Internal reference.
) (
    input  wire logic                    ref_clk,             // 250 MHz system clock.
    input  wire logic                    rst,                 // Synchronous reset.
    input  wire logic [7:0]              io_addr,             // Register offset.
    input  wire logic [7:0]              io_wdata,            // Write data.
    input  wire logic                    io_wr,               // Write strobe.
    input  wire logic                    io_rd,               // Read strobe.
    output      logic [7:0]              io_rdata,            // Read data, registered.
    input  wire logic                    slow_clock_pin,      // External 32.768 kHz.
    input  wire logic                    speed_sense_input_1, // Tach, fan 1.
    input  wire logic                    speed_sense_input_2, // Tach, fan 2.
    output      logic [NUM_FANS-1:0]     fan_speed_out,       // PWM outputs.
    output      logic                    wake_event,          // Wake request level.
    output      logic                    mgmt_irq             // Management interrupt level.
);

    // -------------------------------------------------------------------------
    // Register state.
    // -------------------------------------------------------------------------
    logic [7:0]          fan_pwm_q [NUM_FANS]; // Per-fan PWM settings.
    logic [7:0]          fan_ctrl_q;           // Shared divisor and clock control.
    logic [7:0]          preload_q [NUM_FANS]; // Tach preload values.
    logic [7:0]          event_en_q;           // Wake and management enables.
    logic [7:0]          slow_cfg_q;           // Slow clock configuration.
    logic [NUM_FANS-1:0] fail_q;               // Sticky failure flags.
    logic [NUM_FANS-1:0] reload_q;             // One-cycle preload write pulses.
    logic [7:0]          rdata_q;              // Read data holding register.
    logic                wake_q;               // Registered wake output.
    logic                mgmt_q;               // Registered management output.

    // Per-fan wires collected from the channel engines.
    logic [NUM_FANS-1:0] limit_hit;            // Count at or above 192.
    logic [7:0]          count_w   [NUM_FANS]; // Live counts for readback.

    // -------------------------------------------------------------------------
    // Pin synchronisers.
    // -------------------------------------------------------------------------
    // Stage one is read only by stage two; the third stage exists purely so the
    // edge detector compares two settled samples.
    logic [2:0] meta_q;   // First stage: slow pin, tach 2, tach 1.
    logic [2:0] sync_q;   // Second stage.
    logic [2:0] prev_q;   // Delayed copy for edge detection.
    logic [2:0] rise;     // Rising edges of the synchronised pins.

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
            prev_q <= 3'h0;
        end else begin
            meta_q <= {slow_clock_pin, speed_sense_input_2, speed_sense_input_1};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign rise = sync_q & ~prev_q;

    // -------------------------------------------------------------------------
    // Slow reference tick.
    // -------------------------------------------------------------------------
    // The internal reference is a divider on the system clock. It is only an
    // approximation of 32.768 kHz because the ratio is not a whole number.
    logic [15:0] slow_div_q; // Internal reference divider.
    logic        int_tick;   // Internal reference tick.
    logic        slow_tick;  // Selected reference tick.

    always_ff @(posedge ref_clk) begin
        if (rst || int_tick) begin
            slow_div_q <= 16'h0000;
        end else begin
            slow_div_q <= 16'(slow_div_q + 16'h0001);
        end
    end

    assign int_tick = (slow_div_q == 16'(SLOW_TICK_CYCLES - 1));

    // Choose the pin when software reports it present, else the internal one.
    assign slow_tick = slow_cfg_q[EXT_PRESENT_BIT] ? rise[2] : int_tick;

    // -------------------------------------------------------------------------
    // Register writes.
    // -------------------------------------------------------------------------
    // PWM settings, one per fan; no side effects beyond storing.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fan_pwm_q[0] <= FAN_PWM_RESET;
            fan_pwm_q[1] <= FAN_PWM_RESET;
        end else if (io_wr && io_addr == OFS_FAN_PWM_1) begin
            fan_pwm_q[0] <= io_wdata;
        end else if (io_wr && io_addr == OFS_FAN_PWM_2) begin
            fan_pwm_q[1] <= io_wdata;
        end
    end

    // Shared control register; reset value selects divide by two on both fans.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fan_ctrl_q <= FAN_CTRL_RESET;
        end else if (io_wr && io_addr == OFS_FAN_CTRL) begin
            fan_ctrl_q <= io_wdata;
        end
    end

    // Preload registers. A write also reloads the counter on the next cycle,
    // so software sees the new start value without waiting for a tach edge.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            preload_q[0] <= PRELOAD_RESET;
            preload_q[1] <= PRELOAD_RESET;
            reload_q     <= '0;
        end else begin
            reload_q <= '0;
            if (io_wr && io_addr == OFS_PRELOAD_1) begin
                preload_q[0] <= io_wdata;
                reload_q[0]  <= 1'b1;
            end
            if (io_wr && io_addr == OFS_PRELOAD_2) begin
                preload_q[1] <= io_wdata;
                reload_q[1]  <= 1'b1;
            end
        end
    end

    // Event enables and slow clock configuration.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            event_en_q <= EVENT_EN_RESET;
            slow_cfg_q <= SLOW_CFG_RESET;
        end else begin
            if (io_wr && io_addr == OFS_EVENT_EN) begin
                event_en_q <= io_wdata;
            end
            if (io_wr && io_addr == OFS_SLOW_CFG) begin
                slow_cfg_q <= io_wdata;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Failure flags and event outputs.
    // -------------------------------------------------------------------------
    // Writing one clears a flag, but a threshold hit in the same cycle wins so
    // no failure can slip past a clear. While the count stays high the flag
    // comes straight back, which is the intended behaviour for a stalled fan.
    logic [NUM_FANS-1:0] fail_clr; // Write-one-to-clear mask.

    assign fail_clr = (io_wr && io_addr == OFS_FAIL_STS) ? io_wdata[NUM_FANS-1:0] : '0;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fail_q <= '0;
        end else begin
            fail_q <= (fail_q & ~fail_clr) | limit_hit;
        end
    end

    // Outputs follow the flags only where enabled; disabling drops them one clock after the enable register changes.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wake_q <= 1'b0;
            mgmt_q <= 1'b0;
        end else begin
            wake_q <= |(fail_q & event_en_q[WAKE_EN_LSB +: NUM_FANS]);
            mgmt_q <= |(fail_q & event_en_q[MGMT_EN_LSB +: NUM_FANS]);
        end
    end

    assign wake_event = wake_q;
    assign mgmt_irq   = mgmt_q;

    // -------------------------------------------------------------------------
    // Register reads.
    // -------------------------------------------------------------------------
    // Read data is captured on the strobe and held until the next read.
    // Offsets outside the block answer with zero.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (io_rd) begin
            unique case (io_addr)
                OFS_FAN_PWM_1: rdata_q <= fan_pwm_q[0];
                OFS_FAN_PWM_2: rdata_q <= fan_pwm_q[1];
                OFS_FAN_CTRL:  rdata_q <= fan_ctrl_q;
                OFS_PRELOAD_1: rdata_q <= preload_q[0];
                OFS_PRELOAD_2: rdata_q <= preload_q[1];
                OFS_COUNT_1:   rdata_q <= count_w[0];
                OFS_COUNT_2:   rdata_q <= count_w[1];
                OFS_FAIL_STS:  rdata_q <= {6'h00, fail_q};
                OFS_EVENT_EN:  rdata_q <= event_en_q;
                OFS_SLOW_CFG:  rdata_q <= slow_cfg_q;
                default:       rdata_q <= 8'h00;
            endcase
        end
    end

    assign io_rdata = rdata_q;

    // -------------------------------------------------------------------------
    // Per-fan channels.
    // -------------------------------------------------------------------------
    for (genvar f = 0; f < NUM_FANS; f++) begin : g_fan
        fan_chan_if chan ();

        slice_cnt_t slice_div_q; // Cycles left in the current slice.
        slice_cnt_t slice_len;   // Slice length for the selected frequency.
        logic [2:0] freq_sel;    // Source, multiplier and clock select.

        assign freq_sel = {fan_ctrl_q[SRC_BIT[f]],
                           fan_ctrl_q[MULT_BIT[f]],
                           fan_pwm_q[f][CLK_SEL_BIT]};

        // Eight output frequencies; the multiplier halves the slice length.
        always_comb begin
            unique case (freq_sel)
                3'b000: slice_len = slice_cnt_t'(SLICE_CYC_A);
                3'b001: slice_len = slice_cnt_t'(SLICE_CYC_B);
                3'b010: slice_len = slice_cnt_t'(SLICE_CYC_A2);
                3'b011: slice_len = slice_cnt_t'(SLICE_CYC_B2);
                3'b100: slice_len = slice_cnt_t'(SLICE_CYC_SLOW_A);
                3'b101: slice_len = slice_cnt_t'(SLICE_CYC_SLOW_B);
                3'b110: slice_len = slice_cnt_t'(SLICE_CYC_SLOW_A2);
                3'b111: slice_len = slice_cnt_t'(SLICE_CYC_SLOW_B2);
            endcase
        end

        // Down-counter that pulses once per slice. A setting change takes
        // effect at the end of the slice in progress rather than mid-slice.
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                slice_div_q <= '0;
            end else if (slice_div_q == '0) begin
                slice_div_q <= slice_cnt_t'(slice_len - 17'h00001);
            end else begin
                slice_div_q <= slice_cnt_t'(slice_div_q - 17'h00001);
            end
        end

        assign chan.slice_tick = (slice_div_q == '0);
        assign chan.duty_code  = fan_pwm_q[f][DUTY_LSB +: 6];
        assign chan.force_high = fan_pwm_q[f][FORCE_HIGH_BIT];
        assign chan.slow_tick  = slow_tick;
        assign chan.divisor    = fan_ctrl_q[DIV_LSB[f] +: 2];
        assign chan.reload     = reload_q[f];
        assign chan.preload    = preload_q[f];
        assign chan.tach_rise  = rise[f];

        pwm_slicer u_pwm (
            .ref_clk (ref_clk),
            .rst     (rst),
            .chan    (chan.pwm)
        );

        tach_counter u_tach (
            .ref_clk (ref_clk),
            .rst     (rst),
            .chan    (chan.tach)
        );

        assign fan_speed_out[f] = chan.pwm_out;
        assign limit_hit[f]     = chan.limit_hit;
        assign count_w[f]       = chan.count;
    end

endmodule

// File: inc/fan_pkg.sv
package fan_pkg;

    // -------------------------------------------------------------------------
    // Register map and reset values.
    // -------------------------------------------------------------------------
    localparam int          NUM_FANS        = 2;
    localparam logic [7:0]  OFS_FAN_PWM_1   = 8'h56; // Per-fan PWM setting, fan 1.
    localparam logic [7:0]  OFS_FAN_PWM_2   = 8'h57; // Per-fan PWM setting, fan 2.
    localparam logic [7:0]  OFS_FAN_CTRL    = 8'h58; // Shared clock and divisor control.
    localparam logic [7:0]  OFS_PRELOAD_1   = 8'h59; // Tach preload, fan 1.
    localparam logic [7:0]  OFS_PRELOAD_2   = 8'h5A; // Tach preload, fan 2.
    localparam logic [7:0]  OFS_COUNT_1     = 8'h5B; // Live tach count, fan 1.
    localparam logic [7:0]  OFS_COUNT_2     = 8'h5C; // Live tach count, fan 2.
    localparam logic [7:0]  OFS_FAIL_STS    = 8'h5D; // Sticky fan-failure flags.
    localparam logic [7:0]  OFS_EVENT_EN    = 8'h5E; // Wake and management enables.
    localparam logic [7:0]  OFS_SLOW_CFG    = 8'h5F; // Slow clock source configuration.

    localparam logic [7:0]  FAN_PWM_RESET   = 8'h00; // Outputs low after reset.
    localparam logic [7:0]  FAN_CTRL_RESET  = 8'h50; // Both divisors select divide by two.
    localparam logic [7:0]  PRELOAD_RESET   = 8'h00;
    localparam logic [7:0]  EVENT_EN_RESET  = 8'h00;
    localparam logic [7:0]  SLOW_CFG_RESET  = 8'h00;

    // -------------------------------------------------------------------------
    // Field positions.
    // -------------------------------------------------------------------------
    localparam int CLK_SEL_BIT    = 7;  // Per-fan clock select.
    localparam int DUTY_LSB       = 1;  // Duty code occupies bits 6..1.
    localparam int FORCE_HIGH_BIT = 0;  // Per-fan override.
    localparam int DIV_LSB   [NUM_FANS] = '{4, 6}; // Count divisor fields.
    localparam int MULT_BIT  [NUM_FANS] = '{2, 3}; // Clock multiplier bits.
    localparam int SRC_BIT   [NUM_FANS] = '{0, 1}; // Clock source select bits.
    localparam int WAKE_EN_LSB    = 0;  // Wake enables in bits 1..0.
    localparam int MGMT_EN_LSB    = 4;  // Management enables in bits 5..4.
    localparam int EXT_PRESENT_BIT = 0; // External slow clock present.

    // -------------------------------------------------------------------------
    // Timing: clock rate, output frequencies and the derived slice periods.
    // -------------------------------------------------------------------------
    localparam int CLK_HZ       = 250_000_000;
    localparam int PWM_SLICES   = 64;
    localparam int FREQ_A_HZ    = 15625;  // Fast pair, select clear.
    localparam int FREQ_B_HZ    = 23438;  // Fast pair, select set.
    localparam int FREQ_C_HZ    = 40;     // Slow pair, select clear.
    localparam int FREQ_D_HZ    = 60;     // Slow pair, select set.
    localparam int SLOW_CLK_HZ  = 32768;  // Tachometer reference.

    localparam int SLICE_CYC_A    = CLK_HZ / (FREQ_A_HZ * PWM_SLICES);
    localparam int SLICE_CYC_B    = CLK_HZ / (FREQ_B_HZ * PWM_SLICES);
    localparam int SLICE_CYC_A2   = CLK_HZ / (2 * FREQ_A_HZ * PWM_SLICES);
    localparam int SLICE_CYC_B2   = CLK_HZ / (2 * FREQ_B_HZ * PWM_SLICES);
    localparam int SLICE_CYC_C    = CLK_HZ / (FREQ_C_HZ * PWM_SLICES);
    localparam int SLICE_CYC_D    = CLK_HZ / (FREQ_D_HZ * PWM_SLICES);
    localparam int SLICE_CYC_C2   = CLK_HZ / (2 * FREQ_C_HZ * PWM_SLICES);
    localparam int SLICE_CYC_D2   = CLK_HZ / (2 * FREQ_D_HZ * PWM_SLICES);
    localparam int SLOW_TICK_CYC  = CLK_HZ / SLOW_CLK_HZ;

    localparam logic [7:0] TACH_SAT = 8'hFF; // Counter ceiling.

    typedef logic [16:0] slice_cnt_t;        // Wide enough for the slowest slice.

endpackage

// File: inc/fan_chan_if.sv
`timescale 1ns/1ps

// Per-fan bundle between the register side and the two channel engines.
interface fan_chan_if;
    logic       slice_tick;  // One PWM slice has elapsed.
    logic [5:0] duty_code;   // Slices high per period.
    logic       force_high;  // Override to constant high.
    logic       pwm_out;     // Registered PWM level.
    logic       slow_tick;   // One cycle of the 32.768 kHz reference.
    logic [1:0] divisor;     // Count divisor code.
    logic       reload;      // Preload register was written.
    logic [7:0] preload;     // Counter start value.
    logic       tach_rise;   // Rising edge seen on the synchronised tach input.
    logic [7:0] count;       // Live tach count.
    logic       limit_hit;   // Two top bits of the count are set.

    modport ctrl (output slice_tick, duty_code, force_high, slow_tick, divisor,
                  reload, preload, tach_rise, input pwm_out, count, limit_hit);
    modport pwm  (input slice_tick, duty_code, force_high, output pwm_out);
    modport tach (input slow_tick, divisor, reload, preload, tach_rise,
                  output count, limit_hit);
endinterface

// File: verilog/pwm_slicer.sv
`timescale 1ns/1ps

module pwm_slicer
    import fan_pkg::*;
(
    input wire logic ref_clk, // System clock.
    input wire logic rst,     // Synchronous reset, active high.
    fan_chan_if.pwm  chan     // Channel settings and output.
);

    logic [5:0] slice_q; // Position within the 64-slice period.
    logic       out_q;   // Registered output level.

    // Advance one slice per tick; six bits wrap after 64 slices.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            slice_q <= 6'h00;
        end else if (chan.slice_tick) begin
            slice_q <= 6'(slice_q + 6'h01);
        end
    end

    // High while the slice index is below the code, so a zero code never goes
    // high and the full code leaves exactly one low slice per period.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out_q <= 1'b0;
        end else if (chan.force_high) begin
            out_q <= 1'b1;
        end else begin
            out_q <= (slice_q < chan.duty_code);
        end
    end

    assign chan.pwm_out = out_q;

endmodule

// File: verilog/tach_counter.sv
`timescale 1ns/1ps

module tach_counter
    import fan_pkg::*;
(
    input wire logic ref_clk, // System clock.
    input wire logic rst,     // Synchronous reset, active high.
    fan_chan_if.tach chan     // Tach controls and count.
);

    logic [2:0] pre_q;   // Prescaler over reference ticks.
    logic [2:0] mask;    // Prescaler terminal pattern for the divisor.
    logic [7:0] count_q; // Saturating tach count.
    logic       step;    // Count advances this cycle.

    // Divisor codes 0..3 give division by 1, 2, 4 and 8.
    always_comb begin
        unique case (chan.divisor)
            2'b00: mask = 3'h0;
            2'b01: mask = 3'h1;
            2'b10: mask = 3'h3;
            2'b11: mask = 3'h7;
        endcase
    end

    assign step = chan.slow_tick && ((pre_q & mask) == mask);

    // Prescaler restarts with each reload so every period starts aligned.
    always_ff @(posedge ref_clk) begin
        if (rst || chan.reload || chan.tach_rise) begin
            pre_q <= 3'h0;
        end else if (chan.slow_tick) begin
            pre_q <= 3'(pre_q + 3'h1);
        end
    end

    // Reload on a tach edge or a preload write, else count up and stick at ceiling.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_q <= PRELOAD_RESET;
        end else if (chan.reload || chan.tach_rise) begin
            count_q <= chan.preload;
        end else if (step && count_q != TACH_SAT) begin
            count_q <= 8'(count_q + 8'h01);
        end
    end

    assign chan.count     = count_q;
    assign chan.limit_hit = &count_q[7:6];

endmodule

// File: tb/fan_assertions.sv
`timescale 1ns/1ps
module fan_checker
    import fan_pkg::*;
(
    input wire logic                ref_clk,
    input wire logic                rst,
    input wire logic [7:0]          io_addr,
    input wire logic [7:0]          io_wdata,
    input wire logic                io_wr,
    input wire logic                io_rd,
    input wire logic [7:0]          io_rdata,
    input wire logic [NUM_FANS-1:0] fan_speed_out,
    input wire logic                wake_event,
    input wire logic                mgmt_irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [7:0] pwm1_q;
    logic [9:0] idle_q;
    logic       ctrl_wr_q;
    always_ff @(posedge ref_clk) begin
        if (rst) pwm1_q <= 8'h00;
        else if (io_wr && io_addr == OFS_FAN_PWM_1) pwm1_q <= io_wdata;
    end
    // Any write restarts the count, so slice-boundary lag never trips the check.
    always_ff @(posedge ref_clk) begin
        if (rst || io_wr || pwm1_q != 8'h00) idle_q <= 10'h000;
        else if (idle_q != 10'h3FF) idle_q <= idle_q + 10'h001;
    end
    always_ff @(posedge ref_clk) begin
        if (rst) ctrl_wr_q <= 1'b0;
        else if (io_wr && io_addr == OFS_FAN_CTRL) ctrl_wr_q <= 1'b1;
    end
    property p_back(a);
        io_wr && !io_rd && io_addr == a ##1 !io_wr ##1 io_rd && !io_wr && io_addr == a
            |=> io_rdata == $past(io_wdata, 3);
    endproperty
    chk_reset_low: assert property (disable iff (1'b0)
        rst |=> fan_speed_out == 2'b00 && !wake_event && !mgmt_irq) else $error("not low");
    chk_div_default: assert property (
        io_rd && !io_wr && io_addr == OFS_FAN_CTRL && !ctrl_wr_q |=> io_rdata[7:4] == 4'h5)
        else $error("bad divisor");
    chk_pwm_back: assert property (p_back(OFS_FAN_PWM_1)) else $error("pwm lost");
    chk_ctrl_back: assert property (p_back(OFS_FAN_CTRL)) else $error("ctrl lost");
    chk_preload_back: assert property (p_back(OFS_PRELOAD_1)) else $error("lost");
    chk_zero_low: assert property (idle_q > 10'd600 |-> !fan_speed_out[0])
        else $error("zero duty high");
    chk_force_high: assert property (
        io_wr && io_addr == OFS_FAN_PWM_1 && io_wdata[0] |-> ##[1:3] fan_speed_out[0])
        else $error("force ignored");
    chk_events_gated: assert property (
        io_wr && io_addr == OFS_EVENT_EN && io_wdata == 8'h00 |-> ##2 !wake_event && !mgmt_irq)
        else $error("event not gated");
    cover property ($rose(wake_event));
    cover property ($rose(mgmt_irq));
    cover property ($rose(fan_speed_out[1]));
endmodule
bind fan_pwm_and_tach_monitor fan_checker u_chk (.ref_clk, .rst, .io_addr, .io_wdata,
    .io_wr, .io_rd, .io_rdata, .fan_speed_out, .wake_event, .mgmt_irq);

// File: tb/fan_model.sv
`timescale 1ns/1ps
// A fan seen from its tach wire: a square wave, or a still line when stalled.
module fan_model (
    input  wire logic       ref_clk,  // Bench clock.
    input  wire logic [7:0] half_cyc, // Half tach period in clocks, zero when stalled.
    output logic            tach      // Tach output.
);
    int cnt = 0;
    initial tach = 1'b0;
    always @(posedge ref_clk) begin
        cnt = (half_cyc == 0 || cnt + 1 >= half_cyc) ? 0 : cnt + 1;
        if (half_cyc != 0 && cnt == 0) tach <= ~tach;
    end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import fan_pkg::*;
    localparam int SL[4] = '{8, 6, 4, 3};
    logic ref_clk = 1'b0, rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0, slow_clock_pin = 1'b0;
    logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata, d, v, h1 = 8'h00, h2 = 8'h1E;
    logic [1:0] fan_speed_out;
    logic wake_event, mgmt_irq, t1, t2;
    int mismatches = 0, check_count = 0, hi, seed = 32'h11A9;
    logic [7:0] rw[6] = '{8'h56, 8'h57, 8'h58, 8'h59, 8'h5A, 8'h5E};
    logic [7:0] zr[9] = '{8'h56, 8'h57, 8'h59, 8'h5A, 8'h5D, 8'h5E, 8'h5F, 8'h10, 8'h60};
    always #2 ref_clk = ~ref_clk;
    always #20 slow_clock_pin = ~slow_clock_pin;
    fan_pwm_and_tach_monitor #(.SLICE_CYC_SLOW_A(8), .SLICE_CYC_SLOW_B(6),
        .SLICE_CYC_SLOW_A2(4), .SLICE_CYC_SLOW_B2(3), .SLOW_TICK_CYCLES(8)) i_dut (
        .ref_clk, .rst, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata, .slow_clock_pin,
        .speed_sense_input_1(t1), .speed_sense_input_2(t2), .fan_speed_out, .wake_event,
        .mgmt_irq);
    fan_model i_fan_pwm_setting_1 (.ref_clk, .half_cyc(h1), .tach(t1));
    fan_model i_fan_pwm_setting_2 (.ref_clk, .half_cyc(h2), .tach(t2));
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        io_addr = a;
        io_wdata = w;
        io_wr = 1'b1;
        tick(1);
        io_wr = 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a);
        io_addr = a;
        io_rd = 1'b1;
        tick(1);
        io_rd = 1'b0;
        tick(1);
        d = io_rdata;
    endtask
    task automatic cmp(input string n, input int e, input logic [15:0] s, input int tol);
        check_count++;
        if ($isunknown(s) || s > e + tol || s + tol < e) begin
            mismatches++;
            $display("unexpected %s: expected %0d seen %0d", n, e, s);
        end
    endtask
    // Counts high cycles over one whole period, which is exact whatever the phase.
    task automatic measure(input int cyc);
        hi = 0;
        repeat (cyc) begin
            tick(1);
            hi += (fan_speed_out[0] === 1'b1);
        end
    endtask
    // Waits n edges and returns just after the last, where inputs may change.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #200_000;
        mismatches++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        #1 rst = 1'b0;
        cmp("pwm", 0, fan_speed_out, 0);
        rd(OFS_FAN_CTRL);
        cmp("ctrl", 8'h50, d, 0);
        foreach (zr[i]) begin
            rd(zr[i]);
            cmp("reset", 0, d, 0);
        end
        repeat (12) begin
            v = 8'($random(seed));
            d = rw[$unsigned($random(seed)) % 6];
            wr(d, v);
            rd(io_addr);
            cmp("readback", v, d, 0);
        end
        for (int k = 0; k < 4; k++) begin
            v = k == 0 ? 8'h00 : k == 1 ? 8'hFE : {k[0], 6'($random(seed)), 1'b0};
            wr(OFS_FAN_CTRL, {5'b01010, k[1], 2'b01});
            wr(OFS_FAN_PWM_1, v);
            tick(128 * SL[k]);
            measure(64 * SL[k]);
            cmp("high", v[6:1] * SL[k], 16'(hi), 0);
        end
        wr(OFS_FAN_PWM_2, 8'h81);
        wr(OFS_FAN_PWM_1, 8'h01);
        tick(4);
        measure(256);
        cmp("forced", 256, 16'(hi), 0);
        cmp("forced both", 3, fan_speed_out, 0);
        wr(OFS_PRELOAD_2, 8'h00);
        for (int dv = 0; dv < 4; dv++) begin
            wr(OFS_FAN_CTRL, {4'h4 | 4'(dv), 4'h0});
            wr(OFS_PRELOAD_1, 8'h00);
            tick(160 << dv);
            rd(OFS_COUNT_1);
            cmp("count", 20, d, 1);
        end
        wr(OFS_SLOW_CFG, 8'h01);
        wr(OFS_FAN_CTRL, 8'h40);
        wr(OFS_FAIL_STS, 8'h03);
        wr(OFS_PRELOAD_1, 8'h00);
        tick(200);
        rd(OFS_COUNT_1);
        cmp("ext count", 20, d, 2);
        wr(OFS_EVENT_EN, 8'h11);
        wr(OFS_PRELOAD_1, 8'hBF);
        tick(40);
        cmp("events", 3, {wake_event, mgmt_irq}, 0);
        tick(800);
        rd(OFS_COUNT_1);
        cmp("saturate", 8'hFF, d, 0);
        h1 = 8'h14;
        wr(OFS_PRELOAD_1, 8'h20);
        tick(100);
        rd(OFS_FAIL_STS);
        cmp("sticky", 1, d, 0);
        wr(OFS_EVENT_EN, 8'h00);
        tick(3);
        cmp("masked", 0, {wake_event, mgmt_irq}, 0);
        test_done();
    end
endmodule
